// ---- src/ivm_pkg.sv ----
// Purpose: Shared constants and types for the interrupt vector address map
// Assumes: 20-bit (1 MB) address space, byte-wide vector reads
// Notes: Vector numbers are the relocatable table indices
package ivm_pkg;
	// ==========================================
	// Address space and vector layout
	localparam int ADDR_W = 20;
	localparam int VEC_BYTES = 4;
	localparam int REL_TABLE_BYTES = 256;
	localparam logic [19:0] FIX_UNDEF = 20'hfffdc;
	localparam logic [19:0] FIX_OVF = 20'hfffe0;
	localparam logic [19:0] FIX_BRK = 20'hfffe4;
	localparam logic [19:0] FIX_AMATCH = 20'hfffe8;
	localparam logic [19:0] FIX_SSTEP = 20'hfffec;
	localparam logic [19:0] FIX_WDT = 20'hffff0;
	localparam logic [19:0] FIX_DBC = 20'hffff4;
	localparam logic [19:0] FIX_RESET = 20'hffffc;
	localparam logic [19:0] FIX_TOP = 20'hfffff;
	localparam logic [19:0] BRK_PROBE = 20'hfffe7;
	localparam logic [7:0] BRK_REDIRECT = 8'hff;
	localparam logic [19:0] PC_RST = 20'h00000;
	localparam logic [7:0] ID_RST = 8'h00;
	// ==========================================
	// Vector numbers
	localparam logic [5:0] N_BRK = 6'h00;
	localparam logic [5:0] N_EXT3 = 6'h04;
	localparam logic [5:0] N_TIN5 = 6'h05;
	localparam logic [5:0] N_SLOT6 = 6'h06;
	localparam logic [5:0] N_SLOT7 = 6'h07;
	localparam logic [5:0] N_SLC1 = 6'h08;
	localparam logic [5:0] N_SLC2 = 6'h09;
	localparam logic [5:0] N_S2COLL = 6'h0a;
	localparam logic [5:0] N_DMA0 = 6'h0b;
	localparam logic [5:0] N_DMA1 = 6'h0c;
	localparam logic [5:0] N_KEY = 6'h0d;
	localparam logic [5:0] N_AD = 6'h0e;
	localparam logic [5:0] N_S2TX = 6'h0f;
	localparam logic [5:0] N_S2RX = 6'h10;
	localparam logic [5:0] N_S0TX = 6'h11;
	localparam logic [5:0] N_S0RX = 6'h12;
	localparam logic [5:0] N_S1TX = 6'h13;
	localparam logic [5:0] N_S1RX = 6'h14;
	localparam logic [5:0] N_TOUT0 = 6'h15;
	localparam logic [5:0] N_TIN0 = 6'h1a;
	localparam logic [5:0] N_EXT0 = 6'h1d;
	localparam logic [5:0] N_EXT1 = 6'h1e;
	localparam logic [5:0] N_EXT2 = 6'h1f;
	localparam logic [5:0] N_SOFT_NM = 6'h20;
	// ==========================================
	// Types
	typedef enum logic [3:0] {
		K_UNDEF = 4'h0, K_OVF = 4'h1, K_BRK = 4'h2, K_AMATCH = 4'h3,
		K_SSTEP = 4'h4, K_WDT = 4'h5, K_DBC = 4'h6, K_RESET = 4'h7,
		K_SOFT = 4'h8, K_PERIPH = 4'h9
	} ivm_kind_type;
	typedef enum logic [4:0] {
		SRC_EXT_IRQ_PIN_3, SRC_TIN5, SRC_TIN4, SRC_S1COLL, SRC_TIN3,
		SRC_S0COLL, SRC_SLC1, SRC_SLC2, SRC_S2COLL, SRC_DMA0, SRC_DMA1,
		SRC_KEY, SRC_AD, SRC_S2TX, SRC_S2RX, SRC_S0TX, SRC_S0RX,
		SRC_S1TX, SRC_S1RX, SRC_TOUT0, SRC_TOUT1, SRC_TOUT2, SRC_TOUT3,
		SRC_TOUT4, SRC_TIN0, SRC_TIN1, SRC_TIN2, SRC_EXT_IRQ_PIN_0,
		SRC_EXT_IRQ_PIN_1, SRC_EXT_IRQ_PIN_2
	} ivm_src_type;
	typedef enum logic [3:0] {
		S_IDLE = 4'h1, S_PROBE = 4'h2, S_FETCH = 4'h4, S_LOAD = 4'h8
	} ivm_state_type;
endpackage

// ---- src/ivm_vec_calc.sv ----
// Purpose: First byte address of the vector for one interrupt
// Assumes: Base pointer already captured by the caller
// Notes: Purely combinational
`timescale 1ns/1ps
module ivm_vec_calc (
	// Selection
	input wire ivm_pkg::ivm_kind_type i_kind,
	input wire logic [5:0] i_num,
	input wire logic [19:0] i_base,
	// Result
	output logic [19:0] o_addr
);
	// ==========================================
	// Address decode
	always_comb begin
		case (i_kind)
			ivm_pkg::K_UNDEF: o_addr = ivm_pkg::FIX_UNDEF;
			ivm_pkg::K_OVF: o_addr = ivm_pkg::FIX_OVF;
			ivm_pkg::K_BRK: o_addr = ivm_pkg::FIX_BRK;
			ivm_pkg::K_AMATCH: o_addr = ivm_pkg::FIX_AMATCH;
			ivm_pkg::K_SSTEP: o_addr = ivm_pkg::FIX_SSTEP;
			ivm_pkg::K_WDT: o_addr = ivm_pkg::FIX_WDT;
			ivm_pkg::K_DBC: o_addr = ivm_pkg::FIX_DBC;
			ivm_pkg::K_RESET: o_addr = ivm_pkg::FIX_RESET;
			// Wraps inside 1 MB, an odd base costs no extra cycles
			default: o_addr = i_base + {12'h000, i_num, 2'b00};
		endcase
	end
endmodule

// ---- src/ivm_vector_map.sv ----
// Purpose: Turn an accepted interrupt into a fetched routine start address
// Assumes: Byte read port with one-cycle ack, all inputs on i_core_clk
// Notes: Arbitration, flag saving and stacking live elsewhere
`timescale 1ns/1ps
module ivm_vector_map #(
	parameter bit FLASH_VARIANT = 1'b1
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Accepted interrupt
	input wire logic i_accept,
	input wire ivm_pkg::ivm_kind_type i_kind,
	input wire logic [5:0] i_soft_num,
	input wire ivm_pkg::ivm_src_type i_src,
	// Configuration
	input wire logic [19:0] i_vector_table_base,
	input wire logic i_slot6_source_sel,
	input wire logic i_slot7_source_sel,
	// Vector byte reads
	output logic o_rd_req,
	output logic [19:0] o_rd_addr,
	input wire logic i_rd_ack,
	input wire logic [7:0] i_rd_data,
	// Result
	output logic o_busy,
	output logic o_reject,
	output logic o_pc_load,
	output logic [19:0] o_pc,
	output logic [5:0] o_int_num,
	output logic o_nonmaskable,
	output logic [7:0] o_id_byte,
	output logic o_id_valid
);
	// ==========================================
	// Source to vector number
	// Returns {routed, number}; an unselected shared source is not routed
	function automatic logic [6:0] src_num(input ivm_pkg::ivm_src_type s,
		input logic sel6, input logic sel7);
		logic [6:0] r;
		r = {1'b1, 6'h00};
		case (s)
			ivm_pkg::SRC_EXT_IRQ_PIN_3: r[5:0] = ivm_pkg::N_EXT3;
			ivm_pkg::SRC_TIN5: r[5:0] = ivm_pkg::N_TIN5;
			ivm_pkg::SRC_TIN4: r = {!sel6, ivm_pkg::N_SLOT6};
			ivm_pkg::SRC_S1COLL: r = {sel6, ivm_pkg::N_SLOT6};
			ivm_pkg::SRC_TIN3: r = {!sel7, ivm_pkg::N_SLOT7};
			ivm_pkg::SRC_S0COLL: r = {sel7, ivm_pkg::N_SLOT7};
			ivm_pkg::SRC_SLC1: r[5:0] = ivm_pkg::N_SLC1;
			ivm_pkg::SRC_SLC2: r[5:0] = ivm_pkg::N_SLC2;
			ivm_pkg::SRC_S2COLL: r[5:0] = ivm_pkg::N_S2COLL;
			ivm_pkg::SRC_DMA0: r[5:0] = ivm_pkg::N_DMA0;
			ivm_pkg::SRC_DMA1: r[5:0] = ivm_pkg::N_DMA1;
			ivm_pkg::SRC_KEY: r[5:0] = ivm_pkg::N_KEY;
			ivm_pkg::SRC_AD: r[5:0] = ivm_pkg::N_AD;
			ivm_pkg::SRC_S2TX: r[5:0] = ivm_pkg::N_S2TX;
			ivm_pkg::SRC_S2RX: r[5:0] = ivm_pkg::N_S2RX;
			ivm_pkg::SRC_S0TX: r[5:0] = ivm_pkg::N_S0TX;
			ivm_pkg::SRC_S0RX: r[5:0] = ivm_pkg::N_S0RX;
			ivm_pkg::SRC_S1TX: r[5:0] = ivm_pkg::N_S1TX;
			ivm_pkg::SRC_S1RX: r[5:0] = ivm_pkg::N_S1RX;
			ivm_pkg::SRC_TOUT0: r[5:0] = ivm_pkg::N_TOUT0;
			ivm_pkg::SRC_TOUT1: r[5:0] = ivm_pkg::N_TOUT0 + 6'h01;
			ivm_pkg::SRC_TOUT2: r[5:0] = ivm_pkg::N_TOUT0 + 6'h02;
			ivm_pkg::SRC_TOUT3: r[5:0] = ivm_pkg::N_TOUT0 + 6'h03;
			ivm_pkg::SRC_TOUT4: r[5:0] = ivm_pkg::N_TOUT0 + 6'h04;
			ivm_pkg::SRC_TIN0: r[5:0] = ivm_pkg::N_TIN0;
			ivm_pkg::SRC_TIN1: r[5:0] = ivm_pkg::N_TIN0 + 6'h01;
			ivm_pkg::SRC_TIN2: r[5:0] = ivm_pkg::N_TIN0 + 6'h02;
			ivm_pkg::SRC_EXT_IRQ_PIN_0: r[5:0] = ivm_pkg::N_EXT0;
			ivm_pkg::SRC_EXT_IRQ_PIN_1: r[5:0] = ivm_pkg::N_EXT1;
			// Pin 2 and display_source_2 share one request
			ivm_pkg::SRC_EXT_IRQ_PIN_2: r[5:0] = ivm_pkg::N_EXT2;
			default: r = 7'h00;
		endcase
		return r;
	endfunction

	// ==========================================
	// State
	ivm_pkg::ivm_state_type st_q;
	ivm_pkg::ivm_kind_type kind_q;
	logic [19:0] base_q;
	logic [19:0] rd_addr_q;
	logic [1:0] idx_q;
	logic [19:0] pc_acc_q;
	logic [19:0] pc_q;
	logic [5:0] num_q;
	logic nm_q;
	logic load_q;
	logic reject_q;
	logic [7:0] id_q;
	logic id_v_q;

	// ==========================================
	// Decode of the incoming request
	logic take;
	logic [6:0] pmap;
	logic routed;
	logic [5:0] acc_num;
	logic fixed_kind;
	ivm_pkg::ivm_kind_type calc_kind;
	logic [5:0] calc_num;
	logic [19:0] calc_base;
	logic [19:0] calc_addr;
	logic last_ack;
	logic redirect;

	assign take = i_accept && (st_q == ivm_pkg::S_IDLE);
	assign pmap = src_num(i_src, i_slot6_source_sel, i_slot7_source_sel);
	assign routed = (i_kind != ivm_pkg::K_PERIPH) || pmap[6];
	// Trap numbers reuse the same table slots as peripherals
	assign acc_num = (i_kind == ivm_pkg::K_PERIPH) ? pmap[5:0] :
		(i_kind == ivm_pkg::K_SOFT) ? i_soft_num : ivm_pkg::N_BRK;
	assign fixed_kind = (kind_q != ivm_pkg::K_SOFT) && (kind_q != ivm_pkg::K_PERIPH);
	assign last_ack = (st_q == ivm_pkg::S_FETCH) && i_rd_ack && (idx_q == 2'd3);
	assign redirect = (i_rd_data == ivm_pkg::BRK_REDIRECT);

	// Outside idle the calculator serves the break redirect to entry zero
	always_comb begin
		if (st_q == ivm_pkg::S_IDLE) begin
			calc_kind = i_kind;
			calc_num = acc_num;
			calc_base = i_vector_table_base;
		end else begin
			calc_kind = ivm_pkg::K_SOFT;
			calc_num = ivm_pkg::N_BRK;
			calc_base = base_q;
		end
	end

	ivm_vec_calc u_calc (
		.i_kind(calc_kind),
		.i_num(calc_num),
		.i_base(calc_base),
		.o_addr(calc_addr)
	);

	// ==========================================
	// Sequencer
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_q <= ivm_pkg::S_IDLE;
		end else begin
			case (st_q)
				ivm_pkg::S_IDLE: begin
					if (take && routed) begin
						st_q <= (i_kind == ivm_pkg::K_BRK) ? ivm_pkg::S_PROBE :
							ivm_pkg::S_FETCH;
					end
				end
				ivm_pkg::S_PROBE: begin
					if (i_rd_ack) begin
						st_q <= ivm_pkg::S_FETCH;
					end
				end
				ivm_pkg::S_FETCH: begin
					if (last_ack) begin
						st_q <= ivm_pkg::S_LOAD;
					end
				end
				ivm_pkg::S_LOAD: st_q <= ivm_pkg::S_IDLE;
				default: st_q <= ivm_pkg::S_IDLE;
			endcase
		end
	end

	// Request capture; base is frozen so a rewrite mid-fetch cannot tear it
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			kind_q <= ivm_pkg::K_RESET;
			base_q <= ivm_pkg::PC_RST;
			num_q <= 6'h00;
			nm_q <= 1'b0;
		end else if (take && routed) begin
			kind_q <= i_kind;
			base_q <= i_vector_table_base;
			num_q <= acc_num;
			nm_q <= (i_kind != ivm_pkg::K_PERIPH);
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			reject_q <= 1'b0;
		end else begin
			reject_q <= take && !routed;
		end
	end

	// ==========================================
	// Vector byte reads
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			rd_addr_q <= ivm_pkg::PC_RST;
			idx_q <= 2'd0;
		end else if (take && routed) begin
			idx_q <= 2'd0;
			if (i_kind == ivm_pkg::K_BRK) begin
				rd_addr_q <= ivm_pkg::BRK_PROBE;
			end else begin
				rd_addr_q <= calc_addr;
			end
		end else if ((st_q == ivm_pkg::S_PROBE) && i_rd_ack) begin
			rd_addr_q <= redirect ? calc_addr : ivm_pkg::FIX_BRK;
		end else if ((st_q == ivm_pkg::S_FETCH) && i_rd_ack) begin
			// Lowest byte first, one vector is exactly four bytes
			rd_addr_q <= rd_addr_q + 20'h00001;
			idx_q <= idx_q + 2'd1;
		end
	end

	// Little-endian assembly; the fourth byte holds no address bits
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pc_acc_q <= ivm_pkg::PC_RST;
		end else if ((st_q == ivm_pkg::S_FETCH) && i_rd_ack) begin
			case (idx_q)
				2'd0: pc_acc_q[7:0] <= i_rd_data;
				2'd1: pc_acc_q[15:8] <= i_rd_data;
				2'd2: pc_acc_q[19:16] <= i_rd_data[3:0];
				default: pc_acc_q <= pc_acc_q;
			endcase
		end
	end

	// High vector byte of a fixed slot feeds the flash ID check
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			id_q <= ivm_pkg::ID_RST;
			id_v_q <= 1'b0;
		end else begin
			id_v_q <= 1'b0;
			if (FLASH_VARIANT && last_ack && fixed_kind) begin
				id_q <= i_rd_data;
				id_v_q <= 1'b1;
			end
		end
	end

	// ==========================================
	// Program counter load
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			pc_q <= ivm_pkg::PC_RST;
			load_q <= 1'b0;
		end else begin
			load_q <= last_ack;
			if (last_ack) begin
				pc_q <= pc_acc_q;
			end
		end
	end

	assign o_rd_req = (st_q == ivm_pkg::S_PROBE) || (st_q == ivm_pkg::S_FETCH);
	assign o_rd_addr = rd_addr_q;
	assign o_busy = (st_q != ivm_pkg::S_IDLE);
	assign o_reject = reject_q;
	assign o_pc_load = load_q;
	assign o_pc = pc_q;
	assign o_int_num = num_q;
	assign o_nonmaskable = nm_q;
	assign o_id_byte = id_q;
	assign o_id_valid = id_v_q;

	// ==========================================
	// Checks
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	AST_FIXED_RANGE: assert property (
		(o_rd_req && fixed_kind && !(kind_q == ivm_pkg::K_BRK && st_q == ivm_pkg::S_FETCH
			&& rd_addr_q < ivm_pkg::FIX_UNDEF))
		|-> (o_rd_addr >= ivm_pkg::FIX_UNDEF) && (o_rd_addr <= ivm_pkg::FIX_TOP))
		else $error("fixed vector read outside the fixed table");
	AST_UNDEF_SLOT: assert property (
		(take && i_kind == ivm_pkg::K_UNDEF) |=> (o_rd_addr == ivm_pkg::FIX_UNDEF))
		else $error("undefined opcode vector address wrong");
	AST_OVF_SLOT: assert property (
		(take && i_kind == ivm_pkg::K_OVF) |=> (o_rd_addr == ivm_pkg::FIX_OVF))
		else $error("overflow vector address wrong");
	AST_BRK_PROBE: assert property (
		(take && i_kind == ivm_pkg::K_BRK)
		|=> (st_q == ivm_pkg::S_PROBE) && (o_rd_addr == ivm_pkg::BRK_PROBE))
		else $error("break probe not issued");
	AST_BRK_ROUTE: assert property (
		(st_q == ivm_pkg::S_PROBE && i_rd_ack)
		|=> (o_rd_addr == ($past(i_rd_data) == ivm_pkg::BRK_REDIRECT ? base_q
			: ivm_pkg::FIX_BRK)))
		else $error("break vector routing wrong");
	AST_WDT_SLOT: assert property (
		(take && i_kind == ivm_pkg::K_WDT) |=> (o_rd_addr == ivm_pkg::FIX_WDT))
		else $error("watchdog vector address wrong");
	AST_REL_ENTRY: assert property (
		(take && i_kind == ivm_pkg::K_SOFT)
		|=> (o_rd_addr == $past(i_vector_table_base) + {12'h000, $past(i_soft_num), 2'b00}))
		else $error("relocatable entry address wrong");
	AST_SOFT_NM: assert property (
		(take && i_kind == ivm_pkg::K_SOFT && i_soft_num >= ivm_pkg::N_SOFT_NM)
		|=> o_nonmaskable)
		else $error("high software number reported maskable");
	AST_SLOT6_SEL: assert property (
		(take && i_kind == ivm_pkg::K_PERIPH && i_src == ivm_pkg::SRC_S1COLL
			&& !i_slot6_source_sel) |=> o_reject ##1 !o_busy)
		else $error("unselected slot 6 source was routed");
	AST_LOAD_TIME: assert property (
		last_ack |=> o_pc_load ##1 (!o_pc_load && !o_busy))
		else $error("program counter load not one cycle after last byte");
	// Upper nibble as seen on the bus, kept apart from the assembly path
	logic [3:0] nib_seen_q;
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			nib_seen_q <= 4'h0;
		end else if ((st_q == ivm_pkg::S_FETCH) && i_rd_ack && (idx_q == 2'd2)) begin
			nib_seen_q <= i_rd_data[3:0];
		end
	end
	AST_TOP_NIBBLE: assert property (
		o_pc_load |-> (o_pc[19:16] == nib_seen_q))
		else $error("upper address nibble not carried into program counter");
	AST_ID_BYTE: assert property (
		(last_ack && fixed_kind && FLASH_VARIANT)
		|=> o_id_valid && (o_id_byte == $past(i_rd_data)))
		else $error("fixed vector high byte not offered for ID check");

	COV_BRK_REDIRECT: cover property (
		st_q == ivm_pkg::S_PROBE && i_rd_ack && redirect);
	COV_SOFT_HIGH: cover property (
		take && i_kind == ivm_pkg::K_SOFT && i_soft_num >= ivm_pkg::N_SOFT_NM);
	COV_SLOT7_COLL: cover property (
		take && i_src == ivm_pkg::SRC_S0COLL && i_slot7_source_sel
		&& i_kind == ivm_pkg::K_PERIPH);
	COV_PC_LOAD: cover property (o_pc_load);
endmodule

// ---- verification/ivm_vec_mem_model.sv ----
// Purpose: Byte-wide vector memory answering the block's read port
// Assumes: One clock, reads answered after a bench-chosen wait
// Notes: Contents are a fixed address pattern plus one override byte
`timescale 1ns/1ps
module ivm_vec_mem_model (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	// Byte read port
	input wire logic i_rd_req,
	input wire logic [19:0] i_rd_addr,
	output logic o_rd_ack,
	output logic [7:0] o_rd_data,
	// Bench control
	input wire logic [3:0] i_wait,
	input wire logic i_ovr_en,
	input wire logic [19:0] i_ovr_addr,
	input wire logic [7:0] i_ovr_val
);
	// ==========================================
	// Contents and answer
	logic [3:0] cnt_q;
	logic [7:0] last_q;
	logic [7:0] byte_d;
	always_comb begin
		byte_d = i_rd_addr[7:0] ^ i_rd_addr[15:8] ^ {i_rd_addr[19:16], 4'ha};
		if (i_ovr_en && i_ovr_addr == i_rd_addr) begin
			byte_d = i_ovr_val;
		end
	end
	// Data off the ack cycle is inverted so a late sample cannot pass
	assign o_rd_ack = i_rd_req && (cnt_q == i_wait);
	assign o_rd_data = o_rd_ack ? byte_d : ~last_q;
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n || !i_rd_req || o_rd_ack) begin
			cnt_q <= 4'h0;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			last_q <= 8'h00;
		end else if (o_rd_ack) begin
			last_q <= byte_d;
		end
	end
endmodule

// ---- verification/tb_ivm_vector_map.sv ----
// Purpose: Self-checking bench for the vector address map
// Assumes: Inputs change on the falling edge, memory model on the read port
// Notes: Expected bytes come from the bench's own copy of the pattern
`timescale 1ns/1ps
module tb_ivm_vector_map;
	// ==========================================
	// Signals
	logic clk, rst_n, accept, sel6, sel7, rd_req, rd_ack, busy, reject, pc_load, nm, id_valid;
	logic ovr_en;
	logic [3:0] wait_n;
	logic [5:0] soft_num, int_num;
	logic [7:0] rd_data, id_byte;
	logic [19:0] base, rd_addr, pc;
	ivm_pkg::ivm_kind_type kind;
	ivm_pkg::ivm_src_type src;
	int err_total, n_checks;
	localparam int PNUM [30] = '{4, 5, 6, 6, 7, 7, 8, 9, 10, 11, 12, 13, 14, 15, 16,
		17, 18, 19, 20, 21, 22, 23, 24, 25, 26, 27, 28, 29, 30, 31};
	localparam logic [19:0] FADDR [8] = '{20'hfffdc, 20'hfffe0, 20'hfffe4, 20'hfffe8,
		20'hfffec, 20'hffff0, 20'hffff4, 20'hffffc};
	ivm_vector_map #(.FLASH_VARIANT(1'b1)) ivm_vector_map_inst (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_accept(accept), .i_kind(kind),
		.i_soft_num(soft_num), .i_src(src), .i_vector_table_base(base),
		.i_slot6_source_sel(sel6), .i_slot7_source_sel(sel7), .o_rd_req(rd_req),
		.o_rd_addr(rd_addr), .i_rd_ack(rd_ack), .i_rd_data(rd_data), .o_busy(busy),
		.o_reject(reject), .o_pc_load(pc_load), .o_pc(pc), .o_int_num(int_num),
		.o_nonmaskable(nm), .o_id_byte(id_byte), .o_id_valid(id_valid));
	ivm_vec_mem_model ivm_vec_mem_model_inst (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
		.o_rd_ack(rd_ack), .o_rd_data(rd_data), .i_wait(wait_n), .i_ovr_en(ovr_en),
		.i_ovr_addr(20'hfffe7), .i_ovr_val(8'hff));
	// ==========================================
	// Helpers
	function automatic logic [7:0] pat(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {a[19:16], 4'ha};
	endfunction
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks=%0d errors=%0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ==========================================
	// Scenarios
	// One accepted interrupt, from accept to start-address load
	task automatic run_one(input ivm_pkg::ivm_kind_type k, input logic [5:0] n, input int si,
		input logic [19:0] a, input logic [5:0] en, input logic enm, input logic fixed,
		input logic poke);
		logic [7:0] b0, b1, b2, b3;
		int t;
		b0 = pat(a);
		b1 = pat(a + 20'h1);
		b2 = pat(a + 20'h2);
		b3 = pat(a + 20'h3);
		kind = k;
		soft_num = n;
		src = ivm_pkg::ivm_src_type'(si[4:0]);
		accept = 1'b1;
		@(negedge clk);
		accept = 1'b0;
		if (poke) begin
			chk(busy, 20'h1);
			kind = ivm_pkg::K_WDT;
			accept = 1'b1;
			@(negedge clk);
			accept = 1'b0;
		end
		t = 0;
		while (pc_load !== 1'b1 && t < 100) begin
			@(negedge clk);
			t++;
		end
		chk(pc_load, 20'h1);
		chk(pc, {b2[3:0], b1, b0});
		chk(int_num, en);
		chk(nm, enm);
		if (fixed) begin
			chk(id_valid, 20'h1);
			chk(id_byte, b3);
		end
		@(negedge clk);
		chk(busy, 20'h0);
	endtask
	// Shared slot whose source is not the selected one
	task automatic run_rej(input int si, input logic s6, input logic s7);
		logic rej, rq;
		rej = 1'b0;
		rq = 1'b0;
		sel6 = s6;
		sel7 = s7;
		kind = ivm_pkg::K_PERIPH;
		src = ivm_pkg::ivm_src_type'(si[4:0]);
		accept = 1'b1;
		@(negedge clk);
		accept = 1'b0;
		repeat (4) begin
			rej = rej | (reject === 1'b1);
			rq = rq | (rd_req === 1'b1);
			@(negedge clk);
		end
		chk(rej, 20'h1);
		chk(rq, 20'h0);
	endtask
	// ==========================================
	// Clock, watchdog, main sequence
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#100000;
		err_total++;
		complete_run();
	end
	initial begin
		err_total = 0;
		n_checks = 0;
		rst_n = 1'b0;
		accept = 1'b0;
		kind = ivm_pkg::K_UNDEF;
		soft_num = 6'h00;
		src = ivm_pkg::SRC_EXT_IRQ_PIN_3;
		base = 20'h00000;
		sel6 = 1'b0;
		sel7 = 1'b0;
		wait_n = 4'h0;
		ovr_en = 1'b0;
		repeat (3) @(negedge clk);
		rst_n = 1'b1;
		chk(busy, 20'h0);
		chk(pc, 20'h0);
		// Fixed slots, some with slow memory
		for (int i = 0; i < 8; i++) begin
			wait_n = 4'(i % 3);
			run_one(ivm_pkg::ivm_kind_type'(i), 6'h00, 0, FADDR[i], 6'h00, 1'b1, 1'b1, 1'b0);
		end
		// Break redirected to relocatable entry zero
		ovr_en = 1'b1;
		base = 20'h12340;
		run_one(ivm_pkg::K_BRK, 6'h00, 0, base, 6'h00, 1'b1, 1'b0, 1'b0);
		ovr_en = 1'b0;
		// Traps across the table, odd base wrapping past the top
		base = 20'hfffc1;
		wait_n = 4'h1;
		run_one(ivm_pkg::K_SOFT, 6'd0, 0, base, 6'd0, 1'b1, 1'b0, 1'b0);
		run_one(ivm_pkg::K_SOFT, 6'd3, 0, base + 20'd12, 6'd3, 1'b1, 1'b0, 1'b0);
		run_one(ivm_pkg::K_SOFT, 6'd31, 0, base + 20'd124, 6'd31, 1'b1, 1'b0, 1'b0);
		run_one(ivm_pkg::K_SOFT, 6'd32, 0, base + 20'd128, 6'd32, 1'b1, 1'b0, 1'b1);
		run_one(ivm_pkg::K_SOFT, 6'd63, 0, base + 20'd252, 6'd63, 1'b1, 1'b0, 1'b0);
		// Every peripheral source, with shared slots selected
		base = 20'h0a000;
		for (int i = 0; i < 30; i++) begin
			wait_n = 4'(i % 2);
			sel6 = (i == 3);
			sel7 = (i == 5);
			run_one(ivm_pkg::K_PERIPH, 6'h00, i, base + 20'(4 * PNUM[i]), 6'(PNUM[i]), 1'b0, 1'b0, 1'b0);
		end
		run_rej(2, 1'b1, 1'b0);
		run_rej(3, 1'b0, 1'b0);
		run_rej(4, 1'b0, 1'b1);
		run_rej(5, 1'b0, 1'b0);
		complete_run();
	end
endmodule
